/* File: verilog/lpd_card_detect.v */
// low power card detection loop: calibration, standby/sense loop, level detectors, debug
// ============================================================
// Function
// - with dynamic power control, field timer starts after field-enable command completes.
// - average a configured number of I and Q samples before comparing.
// - card detected when I or Q differs from reference beyond the limit.
// - calibration steps receive gain until strength reaches the target.
// - hysteresis band around target stops gain adjustment oscillating.
// - poll crystal ready every configured interval, counted in units of 256 carrier periods, until ready.
// - wake field detector assertion during the loop ends power saving.
// - wake detector reacts to any 13.56 MHz carrier regardless of modulation.
// - skip collision avoidance in payment profile, do it in general profile.
// - collision detector works only at full power, sensitivity from stored value.
// - in card emulation the collision detector reports an external reader field.
// - host selects debug signal; selected value drives an 8-bit converter.
// - loop alternates timed standby and field-on sensing; no detection returns to standby.
// - loop ends on detection, reset, host attention or external field.
// - I and Q references are calibrated and stored before the loop.
module lpd_card_detect #(
  parameter W  = 10,
  parameter TW = 16
) (
  input  wire                 ref_clk_in,
  input  wire                 rst_n_in,
  input  wire                 ce_in,
  input  wire                 start_in,
  input  wire                 dyn_power_ctrl_in,
  input  wire                 field_cmd_done_in,
  input  wire [2:0]           average_sample_count_in,
  input  wire [W-1:0]         calibration_strength_target_in,
  input  wire [W-1:0]         calibration_strength_hysteresis_in,
  input  wire [W-1:0]         detect_difference_limit_in,
  input  wire [TW-1:0]        sensing_field_duration_in,
  input  wire [TW-1:0]        standby_duration_in,
  input  wire [TW-1:0]        crystal_ready_poll_interval_in,
  input  wire                 crystal_ready_in,
  input  wire                 wake_tick_in,
  input  wire                 sample_valid_in,
  input  wire signed [W-1:0]  adc_i_in,
  input  wire signed [W-1:0]  adc_q_in,
  input  wire [W-1:0]         strength_in,
  input  wire                 host_attention_in,
  input  wire                 wake_field_detector_in,
  input  wire                 collision_field_detector_in,
  input  wire                 payment_profile_in,
  input  wire                 card_emulation_in,
  input  wire [7:0]           collision_sensitivity_in,
  input  wire                 debug_sel_valid_in,
  input  wire [2:0]           debug_sel_in,
  output reg                  field_enable_command_out,
  output reg                  field_on_out,
  output reg                  full_power_out,
  output reg  [5:0]           rx_gain_out,
  output reg                  busy_out,
  output reg                  calibrated_out,
  output reg                  card_detected_out,
  output reg                  loop_exit_out,
  output reg  [2:0]           exit_cause_out,
  output reg                  wake_out,
  output reg                  ext_field_out,
  output reg                  collision_avoid_out,
  output reg  [7:0]           collision_sensitivity_out,
  output reg  signed [W-1:0]  ref_i_out,
  output reg  signed [W-1:0]  ref_q_out,
  output reg  [7:0]           first_aux_output_out,
  output reg  [7:0]           second_aux_output_out
);
  `include "lpd_consts.vh"
  // ============================================================
  // states
  localparam S_IDLE    = 4'h0;
  localparam S_XTAL    = 4'h1;
  localparam S_CAL_ON  = 4'h2;
  localparam S_CAL_ADJ = 4'h3;
  localparam S_CAL_REF = 4'h4;
  localparam S_STANDBY = 4'h5;
  localparam S_FCMD    = 4'h6;
  localparam S_SENSE   = 4'h7;
  localparam S_AVG     = 4'h8;
  localparam S_EXIT    = 4'h9;
  localparam C_NONE  = 3'h0;
  localparam C_CARD  = 3'h1;
  localparam C_HOST  = 3'h2;
  localparam C_FIELD = 3'h3;
  localparam C_RESET = 3'h4;

  function [W-1:0] absdiff;
    input signed [W-1:0] a;
    input signed [W-1:0] b;
    reg   signed [W:0]   d;
    begin
      d = {a[W-1], a} - {b[W-1], b};
      absdiff = d[W] ? (~d[W-1:0] + {{(W-1){1'b0}}, 1'b1}) : d[W-1:0];
    end
  endfunction

  function [7:0] dac8;
    input [W-1:0] v;
    begin
      dac8 = v[W-1:W-8];
    end
  endfunction

  // ============================================================
  // pin synchronisers
  wire xtal_s;
  wire host_s;
  wire wfld_s;
  wire cfld_s;
  wire tick_s;
  lpd_sync2 u_sx (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
                  .d_in(crystal_ready_in), .q_out(xtal_s));
  lpd_sync2 u_sh (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
                  .d_in(host_attention_in), .q_out(host_s));
  // wake_field_detector is a pure carrier envelope level, no demodulation here
  lpd_sync2 u_sw (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
                  .d_in(wake_field_detector_in), .q_out(wfld_s));
  lpd_sync2 u_sc (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
                  .d_in(collision_field_detector_in), .q_out(cfld_s));
  lpd_sync2 u_st (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
                  .d_in(wake_tick_in), .q_out(tick_s));
  reg tick_d_ff;
  wire tick_rise = tick_s & ~tick_d_ff;

  // ============================================================
  // averager
  reg  avg_start_ff;
  wire avg_done;
  wire signed [W-1:0] avg_i;
  wire signed [W-1:0] avg_q;
  lpd_avg #(.W(W)) u_avg (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .start_in(avg_start_ff), .log2_count_in(average_sample_count_in),
    .sample_valid_in(sample_valid_in), .i_in(adc_i_in), .q_in(adc_q_in),
    .done_out(avg_done), .i_avg_out(avg_i), .q_avg_out(avg_q));

  // ============================================================
  // control
  reg [3:0]    state_ff;
  reg [TW-1:0] tmr_ff;
  reg [7:0]    carrier_ff;
  reg [2:0]    dbg_sel_ff;
  wire [W:0]   tgt_lo = {1'b0, calibration_strength_target_in} - {1'b0, calibration_strength_hysteresis_in};
  wire [W:0]   tgt_hi = {1'b0, calibration_strength_target_in} + {1'b0, calibration_strength_hysteresis_in};
  wire in_loop = (state_ff == S_STANDBY) || (state_ff == S_FCMD) || (state_ff == S_SENSE) || (state_ff == S_AVG);
  wire hit = (absdiff(avg_i, ref_i_out) > detect_difference_limit_in) ||
             (absdiff(avg_q, ref_q_out) > detect_difference_limit_in);

  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_ff                  <= S_IDLE;
      tmr_ff                    <= `LPD_ZERO16;
      carrier_ff                <= `LPD_ZERO8;
      tick_d_ff                 <= 1'b0;
      avg_start_ff              <= 1'b0;
      dbg_sel_ff                <= 3'h0;
      field_enable_command_out  <= 1'b0;
      field_on_out              <= 1'b0;
      full_power_out            <= 1'b0;
      rx_gain_out               <= `LPD_GAIN_MID;
      busy_out                  <= 1'b0;
      calibrated_out            <= 1'b0;
      card_detected_out         <= 1'b0;
      loop_exit_out             <= 1'b0;
      exit_cause_out            <= C_RESET;
      wake_out                  <= 1'b0;
      ext_field_out             <= 1'b0;
      collision_avoid_out       <= 1'b0;
      collision_sensitivity_out <= `LPD_ZERO8;
      ref_i_out                 <= {W{1'b0}};
      ref_q_out                 <= {W{1'b0}};
      first_aux_output_out      <= `LPD_ZERO8;
      second_aux_output_out     <= `LPD_ZERO8;
    end else if (ce_in) begin
      tick_d_ff     <= tick_s;
      avg_start_ff  <= 1'b0;
      loop_exit_out <= 1'b0;
      busy_out      <= (state_ff != S_IDLE);
      // full power means not in the low-power loop
      full_power_out <= ~in_loop;
      collision_sensitivity_out <= collision_sensitivity_in;
      collision_avoid_out <= ~in_loop & ~payment_profile_in & ~card_emulation_in & cfld_s;
      ext_field_out <= ~in_loop & card_emulation_in & cfld_s;
      if (in_loop && (host_s || wfld_s)) begin
        state_ff       <= S_EXIT;
        exit_cause_out <= host_s ? C_HOST : C_FIELD;
        wake_out       <= 1'b1;
        field_on_out   <= 1'b0;
        field_enable_command_out <= 1'b0;
      end else begin
        case (state_ff)
          S_IDLE: begin
            if (start_in) begin
              state_ff          <= S_XTAL;
              tmr_ff            <= `LPD_ZERO16;
              carrier_ff        <= `LPD_ZERO8;
              wake_out          <= 1'b0;
              card_detected_out <= 1'b0;
              exit_cause_out    <= C_NONE;
            end
          end
          S_XTAL: begin
            // one carrier count per clock stands in for fc/256 prescale
            carrier_ff <= carrier_ff + 8'h01;
            if ({8'h00, carrier_ff} == `LPD_CARRIER_PER_TICK - `LPD_ONE16) begin
              if (tmr_ff + `LPD_ONE16 >= crystal_ready_poll_interval_in) begin
                tmr_ff <= `LPD_ZERO16;
                if (xtal_s) begin
                  state_ff     <= S_CAL_ON;
                  field_on_out <= 1'b1;
                end
              end else begin
                tmr_ff <= tmr_ff + `LPD_ONE16;
              end
            end
          end
          S_CAL_ON: begin
            if (sample_valid_in) begin
              state_ff <= S_CAL_ADJ;
            end
          end
          S_CAL_ADJ: begin
            if (sample_valid_in) begin
              if ({1'b0, strength_in} < tgt_lo) begin
                rx_gain_out <= rx_gain_out + 6'h01;
              end else if ({1'b0, strength_in} > tgt_hi) begin
                rx_gain_out <= rx_gain_out - 6'h01;
              end else begin
                state_ff     <= S_CAL_REF;
                avg_start_ff <= 1'b1;
              end
            end
          end
          S_CAL_REF: begin
            if (avg_done) begin
              ref_i_out      <= avg_i;
              ref_q_out      <= avg_q;
              calibrated_out <= 1'b1;
              field_on_out   <= 1'b0;
              state_ff       <= S_STANDBY;
              tmr_ff         <= `LPD_ZERO16;
            end
          end
          S_STANDBY: begin
            if (tick_rise) begin
              if (tmr_ff + `LPD_ONE16 >= standby_duration_in) begin
                tmr_ff <= `LPD_ZERO16;
                if (dyn_power_ctrl_in) begin
                  state_ff                 <= S_FCMD;
                  field_enable_command_out <= 1'b1;
                end else begin
                  state_ff     <= S_SENSE;
                  field_on_out <= 1'b1;
                end
              end else begin
                tmr_ff <= tmr_ff + `LPD_ONE16;
              end
            end
          end
          S_FCMD: begin
            if (field_cmd_done_in) begin
              field_enable_command_out <= 1'b0;
              field_on_out             <= 1'b1;
              state_ff                 <= S_SENSE;
              tmr_ff                   <= `LPD_ZERO16;
            end
          end
          S_SENSE: begin
            if (tmr_ff + `LPD_ONE16 >= sensing_field_duration_in) begin
              tmr_ff       <= `LPD_ZERO16;
              state_ff     <= S_AVG;
              avg_start_ff <= 1'b1;
            end else begin
              tmr_ff <= tmr_ff + `LPD_ONE16;
            end
          end
          S_AVG: begin
            if (avg_done) begin
              field_on_out <= 1'b0;
              if (hit) begin
                card_detected_out <= 1'b1;
                exit_cause_out    <= C_CARD;
                wake_out          <= 1'b1;
                state_ff          <= S_EXIT;
              end else begin
                state_ff <= S_STANDBY;
              end
            end
          end
          S_EXIT: begin
            loop_exit_out <= 1'b1;
            state_ff      <= S_IDLE;
          end
          default: state_ff <= S_IDLE;
        endcase
      end
      // ============================================================
      // debug observation
      if (debug_sel_valid_in) begin
        dbg_sel_ff <= debug_sel_in;
      end
      case (dbg_sel_ff)
        `LPD_DBG_ADC_I: begin
          second_aux_output_out <= dac8(adc_i_in);
          first_aux_output_out  <= `LPD_ZERO8;
        end
        `LPD_DBG_ADC_Q: begin
          first_aux_output_out  <= dac8(adc_q_in);
          second_aux_output_out <= `LPD_ZERO8;
        end
        `LPD_DBG_AVG_I: begin
          first_aux_output_out  <= dac8(avg_i);
          second_aux_output_out <= dac8(ref_i_out);
        end
        `LPD_DBG_AVG_Q: begin
          first_aux_output_out  <= dac8(avg_q);
          second_aux_output_out <= dac8(ref_q_out);
        end
        `LPD_DBG_STRENGTH: begin
          first_aux_output_out  <= dac8(strength_in);
          second_aux_output_out <= {2'b00, rx_gain_out};
        end
        `LPD_DBG_STATE: begin
          first_aux_output_out  <= {4'h0, state_ff};
          second_aux_output_out <= {5'h00, exit_cause_out};
        end
        default: begin
          first_aux_output_out  <= `LPD_ZERO8;
          second_aux_output_out <= `LPD_ZERO8;
        end
      endcase
    end
  end
endmodule // lpd_card_detect

/* File: verilog/lpd_consts.vh */
// constants shared by the low power card detect block
`ifndef LPD_CONSTS_VH
`define LPD_CONSTS_VH
`define LPD_CARRIER_PER_TICK 16'h0100
`define LPD_DEBUG_SEL_W      3
`define LPD_DBG_ADC_I        3'h1
`define LPD_DBG_ADC_Q        3'h2
`define LPD_DBG_AVG_I        3'h3
`define LPD_DBG_AVG_Q        3'h4
`define LPD_DBG_STRENGTH     3'h5
`define LPD_DBG_STATE        3'h6
`define LPD_DAC_W            8
`define LPD_ZERO8            8'h00
`define LPD_ZERO16           16'h0000
`define LPD_ONE16            16'h0001
`define LPD_GAIN_MID         6'h20
`endif

/* File: verilog/lpd_sync2.v */
// two-flop synchroniser for asynchronous pins
module lpd_sync2 (
  input  wire ref_clk_in,
  input  wire rst_n_in,
  input  wire ce_in,
  input  wire d_in,
  output reg  q_out
);
  reg meta_ff;
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      meta_ff <= 1'b0;
      q_out   <= 1'b0;
    end else if (ce_in) begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end
endmodule // lpd_sync2

/* File: verilog/lpd_avg.v */
// accumulator that averages a power-of-two count of i/q samples
module lpd_avg #(
  parameter W  = 10,
  parameter LW = 4
) (
  input  wire                  ref_clk_in,
  input  wire                  rst_n_in,
  input  wire                  ce_in,
  input  wire                  start_in,
  input  wire [2:0]            log2_count_in,
  input  wire                  sample_valid_in,
  input  wire signed [W-1:0]   i_in,
  input  wire signed [W-1:0]   q_in,
  output reg                   done_out,
  output reg  signed [W-1:0]   i_avg_out,
  output reg  signed [W-1:0]   q_avg_out
);
  `include "lpd_consts.vh"
  localparam AW = W + 8;
  reg signed [AW-1:0] acc_i_ff;
  reg signed [AW-1:0] acc_q_ff;
  reg [7:0]           cnt_ff;
  reg                 busy_ff;
  wire [7:0]          target = 8'h01 << log2_count_in;
  wire signed [AW-1:0] sum_i = acc_i_ff + {{8{i_in[W-1]}}, i_in};
  wire signed [AW-1:0] sum_q = acc_q_ff + {{8{q_in[W-1]}}, q_in};
  wire signed [AW-1:0] shi = sum_i >>> log2_count_in;
  wire signed [AW-1:0] shq = sum_q >>> log2_count_in;
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      acc_i_ff  <= {AW{1'b0}};
      acc_q_ff  <= {AW{1'b0}};
      cnt_ff    <= `LPD_ZERO8;
      busy_ff   <= 1'b0;
      done_out  <= 1'b0;
      i_avg_out <= {W{1'b0}};
      q_avg_out <= {W{1'b0}};
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (start_in) begin
        acc_i_ff <= {AW{1'b0}};
        acc_q_ff <= {AW{1'b0}};
        cnt_ff   <= `LPD_ZERO8;
        busy_ff  <= 1'b1;
      end else if (busy_ff && sample_valid_in) begin
        acc_i_ff <= sum_i;
        acc_q_ff <= sum_q;
        cnt_ff   <= cnt_ff + 8'h01;
        if (cnt_ff + 8'h01 == target) begin
          busy_ff   <= 1'b0;
          done_out  <= 1'b1;
          i_avg_out <= shi[W-1:0];
          q_avg_out <= shq[W-1:0];
        end
      end
    end
  end
endmodule // lpd_avg

/* File: bench/lpd_card_detect_sva.sv */
// concurrent checks on the ports of the card detect block
module lpd_card_detect_sva #(
  parameter W = 10
) (
  input wire                ref_clk_in,
  input wire                rst_n_in,
  input wire                start_in,
  input wire                wake_field_detector_in,
  input wire                payment_profile_in,
  input wire                field_enable_command_out,
  input wire                field_on_out,
  input wire                full_power_out,
  input wire [5:0]          rx_gain_out,
  input wire                busy_out,
  input wire                card_detected_out,
  input wire                loop_exit_out,
  input wire                wake_out,
  input wire                collision_avoid_out,
  input wire signed [W-1:0] ref_i_out,
  input wire signed [W-1:0] ref_q_out
);
  // ============================================================
  // properties
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_exit_one_pulse: assert property (loop_exit_out |=> !loop_exit_out)
    else $error("loop exit pulse lasted more than one cycle");
  a_card_ends_loop: assert property ($rose(card_detected_out) |-> ##[0:3] loop_exit_out)
    else $error("card detection did not end the loop");
  a_wake_ends_loop: assert property ($rose(wake_out) |-> ##[0:3] loop_exit_out)
    else $error("wake without loop exit");
  a_field_wake_exit: assert property ($rose(wake_field_detector_in) && !full_power_out && busy_out
    |-> ##[1:8] loop_exit_out) else $error("external field did not end the loop");
  a_cmd_holds_field: assert property (field_enable_command_out |-> !field_on_out)
    else $error("field on while enable command still running");
  a_gain_unit_step: assert property ($changed(rx_gain_out) |-> rx_gain_out == $past(rx_gain_out) + 6'h01
    || rx_gain_out == $past(rx_gain_out) - 6'h01 || rx_gain_out == 6'h20) else $error("gain jumped");
  a_refs_in_loop: assert property (!full_power_out && !$past(full_power_out)
    |-> $stable(ref_i_out) && $stable(ref_q_out)) else $error("reference changed inside loop");
  a_payment_no_ca: assert property (payment_profile_in && $past(payment_profile_in, 3)
    |-> !collision_avoid_out) else $error("collision avoidance in payment profile");
  a_ca_full_power: assert property (!full_power_out && !$past(full_power_out) |-> !collision_avoid_out)
    else $error("collision avoidance outside full power");
  a_start_busy: assert property (start_in && !busy_out && !loop_exit_out |-> ##[1:2] busy_out)
    else $error("start did not make the block busy");
endmodule // lpd_card_detect_sva

bind lpd_card_detect lpd_card_detect_sva #(.W(W)) u_sva (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .start_in(start_in), .wake_field_detector_in(wake_field_detector_in),
  .payment_profile_in(payment_profile_in), .field_enable_command_out(field_enable_command_out),
  .field_on_out(field_on_out), .full_power_out(full_power_out), .rx_gain_out(rx_gain_out), .busy_out(busy_out),
  .card_detected_out(card_detected_out), .loop_exit_out(loop_exit_out), .wake_out(wake_out),
  .collision_avoid_out(collision_avoid_out), .ref_i_out(ref_i_out), .ref_q_out(ref_q_out));

/* File: bench/lpd_front_end_model.sv */
// receive front end and low frequency oscillator model for the card detect bench
module lpd_front_end_model (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              field_on_in,
  input  wire logic [5:0]        rx_gain_in,
  input  wire logic signed [9:0] i_delta_in,
  input  wire logic signed [9:0] q_delta_in,
  output logic                   sample_valid_out,
  output logic signed [9:0]      adc_i_out,
  output logic signed [9:0]      adc_q_out,
  output logic [9:0]             strength_out,
  output logic                   wake_tick_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] phase_ff;
  logic [3:0] lfo_ff;
  logic       sample_ff;
  // one sample every four clocks and only with the field on
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      phase_ff  <= 2'h0;
      lfo_ff    <= 4'h0;
      sample_ff <= 1'b0;
    end else begin
      phase_ff  <= field_on_in ? phase_ff + 2'h1 : 2'h0;
      lfo_ff    <= lfo_ff + 4'h1;
      sample_ff <= field_on_in && (phase_ff == 2'h3);
    end
  end
  assign sample_valid_out = sample_ff;
  // strength follows gain so calibration can settle; no field, no signal
  assign strength_out  = field_on_in ? {rx_gain_in, 4'h0} : 10'h000;
  assign adc_i_out     = 10'h064 + i_delta_in;
  assign adc_q_out     = 10'h3ce + q_delta_in;
  assign wake_tick_out = lfo_ff[3];
endmodule // lpd_front_end_model

/* File: bench/tb_lpd_card_detect.sv */
// self-checking bench for the low power card detect block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in, rst_n_in, ce_in, start_in, dyn_power_ctrl_in, field_cmd_done_in, crystal_ready_in, wake_tick_in;
  logic sample_valid_in, host_attention_in, wake_field_detector_in, collision_field_detector_in, payment_profile_in;
  logic card_emulation_in, debug_sel_valid_in, field_enable_command_out, field_on_out, full_power_out, busy_out;
  logic calibrated_out, card_detected_out, loop_exit_out, wake_out, ext_field_out, collision_avoid_out, fon_q;
  logic [2:0] average_sample_count_in, debug_sel_in, exit_cause_out;
  logic [5:0] rx_gain_out;
  logic [7:0] collision_sensitivity_in, collision_sensitivity_out, first_aux_output_out, second_aux_output_out;
  logic [9:0] calibration_strength_target_in, calibration_strength_hysteresis_in, detect_difference_limit_in;
  logic [9:0] strength_in;
  logic [15:0] sensing_field_duration_in, standby_duration_in, crystal_ready_poll_interval_in;
  logic signed [9:0] adc_i_in, adc_q_in, ref_i_out, ref_q_out, i_delta, q_delta;
  int errors, checked, rises;

  lpd_card_detect dut (.ref_clk_in, .rst_n_in, .ce_in, .start_in, .dyn_power_ctrl_in, .field_cmd_done_in,
    .average_sample_count_in, .calibration_strength_target_in, .calibration_strength_hysteresis_in,
    .detect_difference_limit_in, .sensing_field_duration_in, .standby_duration_in, .crystal_ready_poll_interval_in,
    .crystal_ready_in, .wake_tick_in, .sample_valid_in, .adc_i_in, .adc_q_in, .strength_in, .host_attention_in,
    .wake_field_detector_in, .collision_field_detector_in, .payment_profile_in, .card_emulation_in,
    .collision_sensitivity_in, .debug_sel_valid_in, .debug_sel_in, .field_enable_command_out, .field_on_out,
    .full_power_out, .rx_gain_out, .busy_out, .calibrated_out, .card_detected_out, .loop_exit_out, .exit_cause_out,
    .wake_out, .ext_field_out, .collision_avoid_out, .collision_sensitivity_out, .ref_i_out, .ref_q_out,
    .first_aux_output_out, .second_aux_output_out);
  lpd_front_end_model u_fe (.ref_clk_in, .rst_n_in, .field_on_in(field_on_out), .rx_gain_in(rx_gain_out),
    .i_delta_in(i_delta), .q_delta_in(q_delta), .sample_valid_out(sample_valid_in), .adc_i_out(adc_i_in),
    .adc_q_out(adc_q_in), .strength_out(strength_in), .wake_tick_out(wake_tick_in));

  // ============================================================
  // clock, watchdog and helpers
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    fon_q <= field_on_out;
    if (field_on_out && !fon_q) rises <= rises + 1;
  end
  initial begin
    #(25 * 20000);
    errors++;
    test_done();
  end
  task automatic step(input int n);
    repeat (n) begin
      @(posedge ref_clk_in);
      #2;
    end
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bounded wait: 0 calibrated, 1 loop exit, 2 field command, 3 field on, else inside loop
  task automatic wait_for(input int sel, input int lim);
    int n = 0;
    logic hit = 1'b0;
    while (!hit && n < lim) begin
      step(1);
      n++;
      case (sel)
        0: hit = calibrated_out;
        1: hit = loop_exit_out;
        2: hit = field_enable_command_out;
        3: hit = field_on_out;
        default: hit = !full_power_out;
      endcase
    end
    chk($sformatf("wait_%0d", sel), 16'h0001, {15'h0000, hit});
  endtask
  task automatic pulse_start();
    start_in = 1'b1;
    step(1);
    start_in = 1'b0;
  endtask
  task automatic test_done();
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ============================================================
  // main sequence
  initial begin
    {rst_n_in, start_in, dyn_power_ctrl_in, field_cmd_done_in, crystal_ready_in, host_attention_in} = 6'h00;
    {wake_field_detector_in, collision_field_detector_in, payment_profile_in, card_emulation_in} = 4'h0;
    {debug_sel_valid_in, debug_sel_in, i_delta, q_delta, rises, fon_q} = 0;
    errors = 0;
    checked = 0;
    ce_in = 1'b1;
    average_sample_count_in = 3'h2;
    calibration_strength_target_in = 10'h240;
    calibration_strength_hysteresis_in = 10'h008;
    detect_difference_limit_in = 10'h014;
    sensing_field_duration_in = 16'h0005;
    standby_duration_in = 16'h0002;
    crystal_ready_poll_interval_in = 16'h0001;
    collision_sensitivity_in = 8'h5a;
    step(1);
    chk("gain_rst", 16'h0020, rx_gain_out);
    chk("cause_rst", 16'h0004, exit_cause_out);
    step(1);
    rst_n_in = 1'b1;
    pulse_start();
    step(600);
    chk("xtal_wait", 16'h0000, rises[15:0]);
    crystal_ready_in = 1'b1;
    wait_for(0, 2000);
    chk("gain_cal", 16'h0024, rx_gain_out);
    chk("ref_i", 16'h0064, ref_i_out);
    chk("ref_q", 16'hffce, ref_q_out);
    i_delta = 10'h014;
    rises = 0;
    step(400);
    chk("no_card", 16'h0000, card_detected_out);
    chk("loop_runs", 16'h0001, rises >= 2);
    chk("ref_i_hold", 16'h0064, ref_i_out);
    q_delta = 10'h3eb;
    wait_for(1, 400);
    chk("card", 16'h0001, card_detected_out);
    chk("cause_card", 16'h0001, exit_cause_out);
    chk("wake_card", 16'h0001, wake_out);
    {i_delta, q_delta} = 0;
    debug_sel_valid_in = 1'b1;
    debug_sel_in = 3'h1;
    step(1);
    debug_sel_valid_in = 1'b0;
    step(4);
    chk("second_aux_output_i", 16'h0019, second_aux_output_out);
    chk("first_aux_output_not_i", 16'h0000, first_aux_output_out);
    debug_sel_valid_in = 1'b1;
    debug_sel_in = 3'h2;
    step(1);
    debug_sel_valid_in = 1'b0;
    step(4);
    chk("first_aux_output_q", 16'h00f3, first_aux_output_out);
    debug_sel_valid_in = 1'b1;
    debug_sel_in = 3'h3;
    step(1);
    debug_sel_valid_in = 1'b0;
    step(4);
    chk("first_aux_output_avg_i", 16'h001e, first_aux_output_out);
    chk("second_aux_output_ref_i", 16'h0019, second_aux_output_out);
    collision_field_detector_in = 1'b1;
    step(5);
    chk("ca_general", 16'h0001, collision_avoid_out);
    chk("ca_sens", 16'h005a, collision_sensitivity_out);
    payment_profile_in = 1'b1;
    step(5);
    chk("ca_payment", 16'h0000, collision_avoid_out);
    card_emulation_in = 1'b1;
    step(5);
    chk("ext_field", 16'h0001, ext_field_out);
    {collision_field_detector_in, payment_profile_in, card_emulation_in} = 3'h0;
    dyn_power_ctrl_in = 1'b1;
    pulse_start();
    wait_for(2, 3000);
    step(10);
    chk("field_wait_cmd", 16'h0000, field_on_out);
    field_cmd_done_in = 1'b1;
    step(1);
    field_cmd_done_in = 1'b0;
    wait_for(3, 10);
    wait_for(4, 3000);
    host_attention_in = 1'b1;
    wait_for(1, 20);
    chk("cause_host", 16'h0002, exit_cause_out);
    {host_attention_in, dyn_power_ctrl_in} = 2'h0;
    pulse_start();
    wait_for(4, 3000);
    wake_field_detector_in = 1'b1;
    wait_for(1, 20);
    chk("cause_field", 16'h0003, exit_cause_out);
    chk("wake_field", 16'h0001, wake_out);
    wake_field_detector_in = 1'b0;
    pulse_start();
    wait_for(4, 3000);
    // clock enable low must freeze the synchronisers, so the request is never seen
    ce_in = 1'b0;
    host_attention_in = 1'b1;
    step(10);
    chk("ce_freeze", 16'h0000, exit_cause_out);
    {ce_in, host_attention_in} = 2'h2;
    rst_n_in = 1'b0;
    step(2);
    chk("cause_reset", 16'h0004, exit_cause_out);
    chk("busy_reset", 16'h0000, busy_out);
    rst_n_in = 1'b1;
    step(2);
    test_done();
  end
endmodule // tb
